// >>> hw/scu_map.vh
// constants for the conditional word store unit
`ifndef SCU_MAP_VH
`define SCU_MAP_VH
`define SCU_OP_STORE_COND 6'h38
`define SCU_OP_LOAD_LINKED 6'h30
`define SCU_OP_HI 31
`define SCU_OP_LO 26
`define SCU_BASE_HI 25
`define SCU_BASE_LO 21
`define SCU_SRC_HI 20
`define SCU_SRC_LO 16
`define SCU_OFS_HI 15
`define SCU_OFS_LO 0
`define SCU_EXC_NONE 3'h0
`define SCU_EXC_TLB_REFILL 3'h1
`define SCU_EXC_TLB_INVALID 3'h2
`define SCU_EXC_TLB_MODIFIED 3'h3
`define SCU_EXC_ADDR_ERROR 3'h4
`define SCU_EXC_WATCH 3'h5
`define SCU_BLOCK_SHIFT 4
`endif

// >>> hw/scu_link_monitor.v
// link flag keeper: set by linked load, cleared by breaking events
`timescale 1ns/10ps
`default_nettype none
`include "scu_map.vh"
module scu_link_monitor #(
    parameter AW = 32,
    parameter BLOCK_SHIFT = `SCU_BLOCK_SHIFT
) (
    input wire sys_clk,
    input wire rst_n,
    input wire link_set,
    input wire [AW-1:0] link_paddr,
    input wire consume,
    input wire exception_return,
    input wire exception_taken,
    input wire snoop_store_valid,
    input wire [AW-1:0] snoop_store_paddr,
    output reg link_flag_reg,
    output reg [AW-1:0] link_addr_reg
);
    wire snoop_hit;
    // block compare; coarse block may give false failure, never false success
    assign snoop_hit = snoop_store_valid &&
        (snoop_store_paddr[AW-1:BLOCK_SHIFT] == link_addr_reg[AW-1:BLOCK_SHIFT]);
    // breaking events win over a linked load in the same cycle; plain loads, stores
    // and prefetches are not inputs here, so they never break the link
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_flag_reg <= 1'b0;
            link_addr_reg <= {AW{1'b0}};
        end else if (exception_return || exception_taken || snoop_hit || consume) begin
            link_flag_reg <= 1'b0;
        end else if (link_set) begin
            link_flag_reg <= 1'b1;
            link_addr_reg <= link_paddr;
        end
    end
endmodule
`default_nettype wire

// >>> hw/scu_store_cond.v
// conditional word store execution unit
`timescale 1ns/10ps
`default_nettype none
`include "scu_map.vh"
module scu_store_cond #(
    parameter AW = 32
) (
    input wire sys_clk,
    input wire rst_n,
    input wire issue_valid,
    input wire [31:0] issue_instr,
    input wire [31:0] base_value,
    input wire [31:0] source_value,
    input wire exception_return,
    input wire exception_taken,
    input wire xlate_done,
    input wire [AW-1:0] xlate_paddr,
    input wire [2:0] xlate_exc,
    input wire [2:0] cache_coherency_attribute,
    input wire mem_ack,
    input wire snoop_store_valid,
    input wire [AW-1:0] snoop_store_paddr,
    output reg busy,
    output reg xlate_req,
    output reg [31:0] xlate_vaddr,
    output reg mem_store_valid,
    output reg [AW-1:0] mem_store_paddr,
    output reg [31:0] mem_store_data,
    output reg [2:0] mem_store_attr,
    output reg wb_valid,
    output reg [4:0] wb_source_result_reg,
    output reg [31:0] wb_data,
    output reg exc_valid,
    output reg [2:0] exc_code,
    output reg [31:0] exc_vaddr,
    output reg link_flag
);
    localparam ST_IDLE = 4'h1;
    localparam ST_XLATE = 4'h2;
    localparam ST_STORE = 4'h4;
    localparam ST_DONE = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // decode helpers
    function is_op;
        input [31:0] instr;
        input [5:0] op;
        begin
            is_op = (instr[`SCU_OP_HI:`SCU_OP_LO] == op);
        end
    endfunction

    // only the permitted exception classes pass, others fold to none
    function [2:0] legal_exc;
        input [2:0] code;
        begin
            case (code)
                `SCU_EXC_TLB_REFILL, `SCU_EXC_TLB_INVALID, `SCU_EXC_TLB_MODIFIED,
                `SCU_EXC_ADDR_ERROR, `SCU_EXC_WATCH: legal_exc = code;
                default: legal_exc = `SCU_EXC_NONE;
            endcase
        end
    endfunction

    // instruction fields captured at issue, held through the whole attempt
    reg [3:0] state_reg;
    reg [4:0] rt_reg;
    reg [31:0] data_reg;
    reg [31:0] vaddr_reg;
    reg flag_sample_reg;

    // decode and address path, combinational from the issue cycle
    wire issue_sc;
    wire issue_ll;
    wire [31:0] eff_addr;
    wire misaligned;
    wire mon_flag;
    wire consume;

    assign issue_sc = issue_valid && (state_reg == ST_IDLE) && is_op(issue_instr, `SCU_OP_STORE_COND);
    // a linked load is seen in any state; no code-region check is made, so a pair
    // spread over a wide region is simply allowed to succeed
    assign issue_ll = issue_valid && is_op(issue_instr, `SCU_OP_LOAD_LINKED);
    assign eff_addr = base_value + {{16{issue_instr[`SCU_OFS_HI]}}, issue_instr[`SCU_OFS_HI:`SCU_OFS_LO]};
    assign misaligned = (eff_addr[1:0] != 2'h0);
    // an attempt that reaches translation uses up the link, pass or fail
    assign consume = (state_reg == ST_XLATE) && xlate_done;

    ////////////////////////////////////////////////////////////////////////
    // link flag keeper; a linked load uses its own base plus offset as address
    scu_link_monitor #(.AW(AW), .BLOCK_SHIFT(`SCU_BLOCK_SHIFT)) u_mon (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .link_set(issue_ll),
        .link_paddr(eff_addr[AW-1:0]),
        .consume(consume),
        .exception_return(exception_return),
        .exception_taken(exception_taken),
        // only coherent agents report stores here; noncoherent I/O traffic is
        // invisible, so it cannot break the link
        .snoop_store_valid(snoop_store_valid),
        .snoop_store_paddr(snoop_store_paddr),
        .link_flag_reg(mon_flag),
        .link_addr_reg()
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer: decode, translate, sample flag once, store, write back
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            rt_reg <= 5'h0;
            data_reg <= 32'h0;
            vaddr_reg <= 32'h0;
            flag_sample_reg <= 1'b0;
            busy <= 1'b0;
            xlate_req <= 1'b0;
            xlate_vaddr <= 32'h0;
            mem_store_valid <= 1'b0;
            mem_store_paddr <= {AW{1'b0}};
            mem_store_data <= 32'h0;
            mem_store_attr <= 3'h0;
            wb_valid <= 1'b0;
            wb_source_result_reg <= 5'h0;
            wb_data <= 32'h0;
            exc_valid <= 1'b0;
            exc_code <= 3'h0;
            exc_vaddr <= 32'h0;
            link_flag <= 1'b0;
        end else begin
            // one-cycle pulses fall back low unless a state raises them
            wb_valid <= 1'b0;
            exc_valid <= 1'b0;
            xlate_req <= 1'b0;
            link_flag <= mon_flag;
            case (state_reg)
                ST_IDLE: begin
                    if (issue_sc) begin
                        rt_reg <= issue_instr[`SCU_SRC_HI:`SCU_SRC_LO];
                        data_reg <= source_value;
                        vaddr_reg <= eff_addr;
                        // a misaligned attempt never reaches translation, so the link survives it
                        if (misaligned) begin
                            exc_valid <= 1'b1;
                            exc_code <= `SCU_EXC_ADDR_ERROR;
                            exc_vaddr <= eff_addr;
                        end else begin
                            busy <= 1'b1;
                            xlate_req <= 1'b1;
                            xlate_vaddr <= eff_addr;
                            state_reg <= ST_XLATE;
                        end
                    end
                end
                ST_XLATE: begin
                    if (xlate_done) begin
                        // a translation fault ends the attempt with no store and no result
                        if (legal_exc(xlate_exc) != `SCU_EXC_NONE) begin
                            exc_valid <= 1'b1;
                            exc_code <= legal_exc(xlate_exc);
                            exc_vaddr <= vaddr_reg;
                            busy <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            // one sample drives both the store and the result
                            flag_sample_reg <= mon_flag;
                            if (mon_flag) begin
                                mem_store_valid <= 1'b1;
                                mem_store_paddr <= xlate_paddr;
                                mem_store_data <= data_reg;
                                mem_store_attr <= cache_coherency_attribute;
                                state_reg <= ST_STORE;
                            end else begin
                                state_reg <= ST_DONE;
                            end
                        end
                    end
                end
                ST_STORE: begin
                    // result waits for memory to accept the word
                    if (mem_ack) begin
                        mem_store_valid <= 1'b0;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // result written last, after any store has been accepted
                    wb_valid <= 1'b1;
                    wb_source_result_reg <= rt_reg;
                    wb_data <= {31'h0, flag_sample_reg};
                    busy <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    // unreachable with one-hot codes; recover to idle
                    busy <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> sim/scu_asserts.sv
// concurrent checks on the conditional word store unit ports
`timescale 1ns/10ps
`default_nettype none
module scu_asserts #(parameter AW = 32) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] base_value,
    input wire logic busy,
    input wire logic xlate_req,
    input wire logic [31:0] xlate_vaddr,
    input wire logic mem_store_valid,
    input wire logic mem_ack,
    input wire logic [31:0] mem_store_data,
    input wire logic wb_valid,
    input wire logic [31:0] wb_data,
    input wire logic exc_valid,
    input wire logic [2:0] exc_code,
    input wire logic exception_return,
    input wire logic exception_taken,
    input wire logic link_flag
);
////////////////////////////////////////////////////////////////
// effective address and acceptance as the unit should see them
wire [31:0] ea = base_value + {{16{issue_instr[15]}}, issue_instr[15:0]};
wire sc_go = issue_valid && !busy && issue_instr[31:26] == 6'h38;
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!rst_n);
a_misalign_exc: assert property (sc_go && ea[1:0] != 2'h0 |=> exc_valid && exc_code == 3'h4)
    else $error("misaligned store without address error");
a_xlate_addr: assert property (sc_go && ea[1:0] == 2'h0 |=> xlate_req && xlate_vaddr == $past(ea))
    else $error("wrong translation address");
a_store_hold: assert property (mem_store_valid && !mem_ack |=> mem_store_valid && $stable(mem_store_data))
    else $error("store dropped before accept");
a_ack_result: assert property (mem_store_valid && mem_ack |-> ##2 wb_valid && wb_data == 32'h1)
    else $error("no success result after store");
a_exc_list: assert property (exc_valid |-> exc_code inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5})
    else $error("exception code outside list");
a_exception_return_clear: assert property (exception_return |-> ##2 !link_flag)
    else $error("link kept after exception return");
a_exc_clear: assert property (exception_taken |-> ##2 !link_flag)
    else $error("link kept after exception");
a_reset_clear: assert property (!$past(rst_n) |-> !link_flag)
    else $error("link set out of reset");
endmodule
bind scu_store_cond scu_asserts #(.AW(AW)) chk (.sys_clk, .rst_n, .issue_valid, .issue_instr, .base_value,
    .busy, .xlate_req, .xlate_vaddr, .mem_store_valid, .mem_ack, .mem_store_data, .wb_valid, .wb_data,
    .exc_valid, .exc_code, .exception_return, .exception_taken, .link_flag);
`default_nettype wire

// >>> sim/scu_mem_model.sv
// translation and memory partner with adjustable answer lag
`timescale 1ns/10ps
`default_nettype none
module scu_mem_model (
    input wire logic sys_clk,
    input wire logic xlate_req,
    input wire logic [31:0] xlate_vaddr,
    input wire logic mem_store_valid,
    input wire logic [31:0] mem_store_data,
    input wire logic [3:0] lag,
    input wire logic [2:0] fault,
    output logic xlate_done,
    output logic [31:0] xlate_paddr,
    output logic [2:0] xlate_exc,
    output logic [2:0] attr,
    output logic mem_ack,
    output logic [31:0] last_data,
    output logic [7:0] stores
);
logic [31:0] va;
////////////////////////////////////////////////////////////////
// identity translation; idle answer lines toggle so stale values never look valid
initial begin
    {xlate_done, mem_ack, stores, last_data, xlate_exc, xlate_paddr} = '0;
    attr = 3'h5; // cached coherent only
    forever begin
        @(negedge sys_clk);
        {xlate_done, mem_ack} = 2'h0;
        {xlate_paddr, xlate_exc} = ~{xlate_paddr, xlate_exc};
        va = xlate_vaddr;
        if (xlate_req) begin
            repeat (lag) @(negedge sys_clk);
            xlate_done = 1'b1;
            xlate_paddr = va; // same address as the translation request
            xlate_exc = fault;
        end else if (mem_store_valid) begin
            repeat (lag) @(negedge sys_clk);
            mem_ack = 1'b1;
            last_data = mem_store_data;
            stores = stores + 8'h1;
        end
    end
end
endmodule
`default_nettype wire

// >>> sim/store_conditional_atomic_unit_test.sv
// self-checking bench for the conditional word store unit
`timescale 1ns/10ps
`default_nettype none
module store_conditional_atomic_unit_test;
logic sys_clk, rst_n, issue_valid, exception_return, exception_taken, snoop_store_valid, xlate_done, mem_ack;
logic busy, xlate_req, mem_store_valid, wb_valid, exc_valid, link_flag;
logic [31:0] issue_instr, base_value, source_value, snoop_store_paddr, xlate_paddr, xlate_vaddr;
logic [31:0] mem_store_paddr, mem_store_data, wb_data, last_data;
logic [2:0] xlate_exc, cache_coherency_attribute, exc_code, fault = 3'h0;
logic [3:0] lag = 4'h0;
logic [7:0] stores;
logic [2:0] mem_store_attr;
logic [4:0] wb_source_result_reg;
logic [31:0] exc_vaddr;
int failures = 0, comparisons = 0, cyc = 0;
scu_store_cond dut (.sys_clk, .rst_n, .issue_valid, .issue_instr, .base_value, .source_value, .exception_return,
    .exception_taken, .xlate_done, .xlate_paddr, .xlate_exc, .cache_coherency_attribute, .mem_ack,
    .snoop_store_valid, .snoop_store_paddr, .busy, .xlate_req, .xlate_vaddr, .mem_store_valid, .mem_store_paddr,
    .mem_store_data, .mem_store_attr, .wb_valid, .wb_source_result_reg, .wb_data, .exc_valid, .exc_code,
    .exc_vaddr, .link_flag);
scu_mem_model mem (.sys_clk, .xlate_req, .xlate_vaddr, .mem_store_valid, .mem_store_data, .lag, .fault,
    .xlate_done, .xlate_paddr, .xlate_exc, .attr(cache_coherency_attribute), .mem_ack, .last_data, .stores);
////////////////////////////////////////////////////////////////
task automatic give_verdict;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
// one instruction pulse, inputs moved on the falling edge only
task automatic issue(input logic [5:0] op, input logic [31:0] base, input logic [15:0] ofs);
    @(negedge sys_clk);
    issue_valid = 1'b1;
    issue_instr = {op, 5'h3, 5'h7, ofs};
    base_value = base;
    source_value = {base[15:0], ofs};
    @(negedge sys_clk);
    issue_valid = 1'b0;
endtask
// result code: wb data, or 0x38 plus exception code; stores counted by the partner
task automatic try_sc(input logic [31:0] base, input logic [15:0] ofs, input logic [31:0] exp, input logic [7:0] nst);
    logic [7:0] s0;
    logic [31:0] res;
    logic [31:0] ea;
    int n;
    s0 = stores;
    ea = base + {{16{ofs[15]}}, ofs};
    n = 0;
    issue(6'h38, base, ofs);
    while (wb_valid !== 1'b1 && exc_valid !== 1'b1 && n < 60) begin
        @(negedge sys_clk);
        n++;
    end
    res = exc_valid === 1'b1 ? {29'h7, exc_code} : (wb_valid === 1'b1 ? wb_data : 32'hbad);
    while (busy !== 1'b0) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
    chk(res, exp);
    chk({24'h0, stores - s0}, {24'h0, nst});
    if (nst != 8'h0) chk(last_data, {base[15:0], ofs});
    if (nst != 8'h0) chk(mem_store_paddr, ea);
    if (nst != 8'h0) chk({29'h0, mem_store_attr}, 32'h5);
    if (exp < 32'h2) chk({27'h0, wb_source_result_reg}, 32'h7);
    if (exp >= 32'h38) chk(exc_vaddr, ea);
endtask
task automatic brk(input logic [1:0] kind, input logic [31:0] pa, input logic [31:0] exp);
    issue(6'h30, 32'h3000, 16'h0);
    @(negedge sys_clk);
    {exception_return, exception_taken, snoop_store_valid} = {kind == 2'h0, kind == 2'h1, kind == 2'h2};
    snoop_store_paddr = pa;
    @(negedge sys_clk);
    {exception_return, exception_taken, snoop_store_valid} = 3'h0;
    try_sc(32'h3000, 16'h0, exp, exp[7:0]);
endtask
task automatic t_ok(input logic [3:0] l);
    lag = l;
    issue(6'h30, 32'h2010, 16'hfff0);
    issue(6'h2b, 32'h2000, 16'h0);
    try_sc(32'h2010, 16'hfff0, 32'h1, 8'h1);
    try_sc(32'h2010, 16'hfff0, 32'h0, 8'h0);
    lag = 4'h0;
endtask
task automatic t_codes;
    for (int k = 1; k < 7; k++) begin
        fault = k[2:0];
        issue(6'h30, 32'h5000, 16'h0);
        try_sc(32'h5000, 16'h0, k == 6 ? 32'h1 : {29'h7, k[2:0]}, {7'h0, k == 6});
        issue(6'h30, 32'h4000, 16'h0);
        if (k < 4) try_sc(32'h4000, k[15:0], {29'h7, 3'h4}, 8'h0);
    end
    fault = 3'h0;
endtask
////////////////////////////////////////////////////////////////
initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
end
always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
        failures++;
        give_verdict;
    end
end
initial begin
    {rst_n, issue_valid, exception_return, exception_taken, snoop_store_valid} = 5'h0;
    {issue_instr, base_value, source_value, snoop_store_paddr} = 128'h0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    try_sc(32'h1000, 16'h0, 32'h0, 8'h0);
    issue(6'h28, 32'h1000, 16'h0);
    chk({31'h0, busy}, 32'h0);
    t_ok(4'h0);
    t_ok(4'h3);
    brk(2'h0, 32'h0, 32'h0);
    brk(2'h1, 32'h0, 32'h0);
    brk(2'h2, 32'h300c, 32'h0);
    brk(2'h2, 32'h3010, 32'h1);
    t_codes;
    give_verdict;
end
endmodule
`default_nettype wire
